// *** hw/dpbwm_addr_ctr.sv ***
// Burst address counter of one port with its 2-bit lane sub-counter.
// Assumes control strobes are active high here and synchronous to clk.
module dpbwm_addr_ctr (
  input wire logic clk,
  input wire logic rst_n,
  input wire dpbwm_pkg::dpbwm_width_t mode,
  input wire logic order,
  input wire logic clear,
  input wire logic load,
  input wire logic advance,
  input wire logic [dpbwm_pkg::ADDR_W-1:0] ext_addr,
  output logic [dpbwm_pkg::ADDR_W-1:0] addr_q,
  output logic [1:0] lane_q
);

  logic [1:0] first_lane;
  logic last_lane;
  logic [1:0] lane_d;

  // ==========================================================
  // Lane ordering
  always_comb
  begin
    first_lane = dpbwm_pkg::LANE_FIRST;
    last_lane = 1'b1;
    lane_d = lane_q;
    case (mode)
      dpbwm_pkg::DPBWM_W18:
      begin
        first_lane = order ? dpbwm_pkg::HALF_HIGH : dpbwm_pkg::LANE_FIRST;
        last_lane = order ? (lane_q == dpbwm_pkg::LANE_FIRST)
                          : (lane_q == dpbwm_pkg::HALF_HIGH);
        lane_d = lane_q ^ dpbwm_pkg::HALF_HIGH;
      end
      dpbwm_pkg::DPBWM_W9:
      begin
        first_lane = order ? dpbwm_pkg::LANE_LAST : dpbwm_pkg::LANE_FIRST;
        last_lane = order ? (lane_q == dpbwm_pkg::LANE_FIRST)
                          : (lane_q == dpbwm_pkg::LANE_LAST);
        lane_d = order ? lane_q - 2'h1 : lane_q + 2'h1;
      end
      default:
      begin
        first_lane = dpbwm_pkg::LANE_FIRST;
        last_lane = 1'b1;
        lane_d = dpbwm_pkg::LANE_FIRST;
      end
    endcase
  end

  // ==========================================================
  // Counter: clear beats load, load beats increment
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_q <= '0;
      lane_q <= dpbwm_pkg::LANE_FIRST;
    end
    else if (clear)
    begin
      addr_q <= '0;
      lane_q <= first_lane;
    end
    else if (load && advance)
    begin
      addr_q <= ext_addr;
      lane_q <= first_lane;
    end
    else if (advance)
    begin
      if (last_lane)
      begin
        addr_q <= addr_q + 15'h1;
        lane_q <= first_lane;
      end
      else
      begin
        lane_q <= lane_d;
      end
    end
  end

endmodule

// *** hw/dpbwm_pkg.sv ***
// Constants, modes and register map of the dual-port bus-width matcher.
// Assumes a single 10 MHz clock and an APB register port with 32-bit data.
package dpbwm_pkg;

  // ==========================================================
  // Geometry
  localparam int ADDR_W = 15;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DATA_W = 36;
  localparam int HALF_W = 18;

  // ==========================================================
  // Port width modes
  typedef enum logic [1:0] {DPBWM_W36, DPBWM_W18, DPBWM_W9} dpbwm_width_t;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [7:0] CFG_OFF = 8'h00;
  localparam logic [7:0] RSTAT_OFF = 8'h04;
  localparam logic [7:0] LSTAT_OFF = 8'h08;

  // Configuration fields
  localparam int CFG_MATCH_BIT = 0;
  localparam int CFG_SIZE_BIT = 1;
  localparam int CFG_ORDER_BIT = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;

  // Status fields: counter address in the low bits, lane above it
  localparam int STAT_LANE_POS = 16;

  // Lane sub-counter constants
  localparam logic [1:0] LANE_FIRST = 2'h0;
  localparam logic [1:0] LANE_LAST = 2'h3;
  localparam logic [1:0] HALF_HIGH = 2'h2;

  // Readback pin positions
  localparam int RB_ADDR_POS = 3;
  localparam int RB_HALF_POS = 2;
  localparam int RB_QUARTER_POS = 1;
  localparam int RB_LOW_BITS = 6;

endpackage

// *** hw/dpbwm_top.sv ***
// Bus-width matching and burst counters of a dual-port 36-bit memory.
// Assumes the array answers mem_rdata for the current mem_addr at once.
//
// How it works
// - Both selects low: full 36-bit words
// - Match and size high: 9-bit byte bus
// - Match high, size low: 18-bit word bus
// - 18-bit order: low half first unless swapped
// - 9-bit lanes count up, or down if swapped
// - Right pins form four 9-bit lanes
// - Order select ignored in 36-bit mode
// - Sub-counter adds two low lane bits
// - Load and advance together load address
// - Advance increments counter every edge in 36-bit, on the last lane when narrow
// - Clear resets the burst counter
// - Hold-and-read drives counter onto pins
// - 36-bit readback: address on pins 3-17
// - Narrow readback layouts, x9 in two cycles
// - Left lane masks gate each 9-bit lane
// - 36-bit right mode passes every bit
// - 18-bit word needs two beats
// - 9-bit needs four beats, upper pins released
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
module dpbwm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic l_load_strobe_n,
  input wire logic l_advance_enable_n,
  input wire logic l_counter_clear_n,
  input wire logic l_write,
  input wire logic l_read,
  input wire logic l_lane0_mask_n,
  input wire logic l_lane1_mask_n,
  input wire logic l_lane2_mask_n,
  input wire logic l_lane3_mask_n,
  input wire logic [dpbwm_pkg::ADDR_W-1:0] l_ext_addr,
  input wire logic [dpbwm_pkg::DATA_W-1:0] l_dq_in,
  output logic [dpbwm_pkg::DATA_W-1:0] l_dq_out,
  output logic [dpbwm_pkg::DATA_W-1:0] l_dq_oe,
  output logic [dpbwm_pkg::ADDR_W-1:0] l_mem_addr,
  output logic [dpbwm_pkg::DATA_W-1:0] l_mem_wdata,
  output logic [dpbwm_pkg::LANES-1:0] l_mem_lane_we,
  input wire logic [dpbwm_pkg::DATA_W-1:0] l_mem_rdata,
  input wire logic r_load_strobe_n,
  input wire logic r_advance_enable_n,
  input wire logic r_counter_clear_n,
  input wire logic r_write,
  input wire logic r_read,
  input wire logic [dpbwm_pkg::ADDR_W-1:0] r_ext_addr,
  input wire logic [dpbwm_pkg::DATA_W-1:0] r_dq_in,
  output logic [dpbwm_pkg::DATA_W-1:0] r_dq_out,
  output logic [dpbwm_pkg::DATA_W-1:0] r_dq_oe,
  output logic [dpbwm_pkg::ADDR_W-1:0] r_mem_addr,
  output logic [dpbwm_pkg::DATA_W-1:0] r_mem_wdata,
  output logic [dpbwm_pkg::LANES-1:0] r_mem_lane_we,
  input wire logic [dpbwm_pkg::DATA_W-1:0] r_mem_rdata
);

  logic [2:0] cfg_q;
  dpbwm_pkg::dpbwm_width_t r_mode;
  logic r_order;
  logic [dpbwm_pkg::ADDR_W-1:0] r_addr;
  logic [1:0] r_lane;
  logic [dpbwm_pkg::ADDR_W-1:0] l_addr;
  logic [1:0] l_lane;
  logic r_hold_read;
  logic l_hold_read;
  logic rb_phase_q;
  logic [dpbwm_pkg::LANES-1:0] l_lane_en;
  logic [dpbwm_pkg::DATA_W-1:0] l_lane_bits;
  logic [dpbwm_pkg::LANES-1:0] r_beat_lanes;
  logic [dpbwm_pkg::DATA_W-1:0] r_beat_wdata;
  logic [dpbwm_pkg::DATA_W-1:0] r_beat_rdata;
  logic [dpbwm_pkg::DATA_W-1:0] r_beat_oe;
  logic [dpbwm_pkg::DATA_W-1:0] r_readback;
  logic [dpbwm_pkg::DATA_W-1:0] l_readback;
  logic apb_setup;
  logic apb_access;
  logic addr_ok;
  logic [31:0] rd_mux;

  // ==========================================================
  // Mode decode
  // An illegal match-low, size-high setting falls back to 36-bit.
  always_comb
  begin
    if (cfg_q[dpbwm_pkg::CFG_MATCH_BIT] && cfg_q[dpbwm_pkg::CFG_SIZE_BIT])
      r_mode = dpbwm_pkg::DPBWM_W9;
    else if (cfg_q[dpbwm_pkg::CFG_MATCH_BIT])
      r_mode = dpbwm_pkg::DPBWM_W18;
    else
      r_mode = dpbwm_pkg::DPBWM_W36;
  end

  // Order only matters when narrow; the counter also ignores it in 36-bit
  assign r_order = cfg_q[dpbwm_pkg::CFG_ORDER_BIT] && (r_mode != dpbwm_pkg::DPBWM_W36);

  // ==========================================================
  // Address counters
  dpbwm_addr_ctr u_r_ctr (
    .clk(pclk),
    .rst_n(presetn),
    .mode(r_mode),
    .order(r_order),
    .clear(!r_counter_clear_n),
    .load(!r_load_strobe_n),
    .advance(!r_advance_enable_n),
    .ext_addr(r_ext_addr),
    .addr_q(r_addr),
    .lane_q(r_lane)
  );

  dpbwm_addr_ctr u_l_ctr (
    .clk(pclk),
    .rst_n(presetn),
    .mode(dpbwm_pkg::DPBWM_W36),
    .order(1'b0),
    .clear(!l_counter_clear_n),
    .load(!l_load_strobe_n),
    .advance(!l_advance_enable_n),
    .ext_addr(l_ext_addr),
    .addr_q(l_addr),
    .lane_q(l_lane)
  );

  assign r_mem_addr = r_addr;
  assign l_mem_addr = l_addr;

  // Hold+read: strobe low, advance high, read cycle; counter is held
  assign r_hold_read = !r_load_strobe_n && r_advance_enable_n && r_read && !r_write;
  assign l_hold_read = !l_load_strobe_n && l_advance_enable_n && l_read && !l_write;

  // ==========================================================
  // Right port lane steering
  always_comb
  begin
    r_beat_lanes = '1;
    r_beat_wdata = r_dq_in;
    r_beat_rdata = r_mem_rdata;
    r_beat_oe = '1;
    case (r_mode)
      dpbwm_pkg::DPBWM_W18:
      begin
        r_beat_lanes = r_lane[1] ? 4'hc : 4'h3;
        r_beat_wdata = {2{r_dq_in[dpbwm_pkg::HALF_W-1:0]}};
        r_beat_rdata = '0;
        r_beat_rdata[dpbwm_pkg::HALF_W-1:0] = r_lane[1]
          ? r_mem_rdata[dpbwm_pkg::DATA_W-1:dpbwm_pkg::HALF_W]
          : r_mem_rdata[dpbwm_pkg::HALF_W-1:0];
        r_beat_oe = {{dpbwm_pkg::HALF_W{1'b0}}, {dpbwm_pkg::HALF_W{1'b1}}};
      end
      dpbwm_pkg::DPBWM_W9:
      begin
        r_beat_lanes = 4'h1 << r_lane;
        r_beat_wdata = {dpbwm_pkg::LANES{r_dq_in[dpbwm_pkg::LANE_W-1:0]}};
        r_beat_rdata = '0;
        r_beat_rdata[dpbwm_pkg::LANE_W-1:0] = r_mem_rdata[r_lane*dpbwm_pkg::LANE_W +: dpbwm_pkg::LANE_W];
        r_beat_oe = {{(dpbwm_pkg::DATA_W-dpbwm_pkg::LANE_W){1'b0}}, {dpbwm_pkg::LANE_W{1'b1}}};
      end
      default:
      begin
        r_beat_lanes = '1;
        r_beat_wdata = r_dq_in;
        r_beat_rdata = r_mem_rdata;
        r_beat_oe = '1;
      end
    endcase
  end

  // ==========================================================
  // Counter readback images
  always_comb
  begin
    r_readback = '0;
    case (r_mode)
      dpbwm_pkg::DPBWM_W18:
      begin
        r_readback[dpbwm_pkg::RB_ADDR_POS +: dpbwm_pkg::ADDR_W] = r_addr;
        r_readback[dpbwm_pkg::RB_HALF_POS] = r_lane[1];
      end
      dpbwm_pkg::DPBWM_W9:
      begin
        if (!rb_phase_q)
        begin
          r_readback[dpbwm_pkg::LANE_W-1:0] =
            r_addr[dpbwm_pkg::ADDR_W-1:dpbwm_pkg::RB_LOW_BITS];
        end
        else
        begin
          r_readback[dpbwm_pkg::RB_QUARTER_POS] = r_lane[0];
          r_readback[dpbwm_pkg::RB_HALF_POS] = r_lane[1];
          r_readback[dpbwm_pkg::RB_ADDR_POS +: dpbwm_pkg::RB_LOW_BITS] =
            r_addr[dpbwm_pkg::RB_LOW_BITS-1:0];
        end
      end
      default:
      begin
        r_readback[dpbwm_pkg::RB_ADDR_POS +: dpbwm_pkg::ADDR_W] = r_addr;
      end
    endcase
  end

  always_comb
  begin
    l_readback = '0;
    l_readback[dpbwm_pkg::RB_ADDR_POS +: dpbwm_pkg::ADDR_W] = l_addr;
  end

  // The x9 readback takes two cycles while the hold+read request stays
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rb_phase_q <= 1'b0;
    else if (r_hold_read && (r_mode == dpbwm_pkg::DPBWM_W9))
      rb_phase_q <= !rb_phase_q;
    else
      rb_phase_q <= 1'b0;
  end

  // ==========================================================
  // Right port data path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_mem_wdata <= '0;
      r_mem_lane_we <= '0;
    end
    else
    begin
      r_mem_wdata <= r_beat_wdata;
      r_mem_lane_we <= r_write ? r_beat_lanes : 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_dq_out <= '0;
      r_dq_oe <= '0;
    end
    else if (r_hold_read)
    begin
      r_dq_out <= r_readback;
      r_dq_oe <= r_beat_oe;
    end
    else if (r_read && !r_write)
    begin
      r_dq_out <= r_beat_rdata;
      r_dq_oe <= r_beat_oe;
    end
    else
    begin
      r_dq_out <= '0;
      r_dq_oe <= '0;
    end
  end

  // ==========================================================
  // Left port data path, always 36-bit with lane masks
  assign l_lane_en = {!l_lane3_mask_n, !l_lane2_mask_n, !l_lane1_mask_n, !l_lane0_mask_n};

  always_comb
  begin
    l_lane_bits = '0;
    for (int i = 0; i < dpbwm_pkg::LANES; i++)
      l_lane_bits[i*dpbwm_pkg::LANE_W +: dpbwm_pkg::LANE_W] = {dpbwm_pkg::LANE_W{l_lane_en[i]}};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      l_mem_wdata <= '0;
      l_mem_lane_we <= '0;
    end
    else
    begin
      l_mem_wdata <= l_dq_in;
      l_mem_lane_we <= l_write ? l_lane_en : 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      l_dq_out <= '0;
      l_dq_oe <= '0;
    end
    else if (l_hold_read)
    begin
      l_dq_out <= l_readback;
      l_dq_oe <= '1;
    end
    else if (l_read && !l_write)
    begin
      l_dq_out <= l_mem_rdata & l_lane_bits;
      l_dq_oe <= l_lane_bits;
    end
    else
    begin
      l_dq_out <= '0;
      l_dq_oe <= '0;
    end
  end

  // ==========================================================
  // APB slave, no wait states: pready rises in the first access cycle
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable && pready;
  assign addr_ok = (paddr == dpbwm_pkg::CFG_OFF) || (paddr == dpbwm_pkg::RSTAT_OFF) ||
                   (paddr == dpbwm_pkg::LSTAT_OFF);

  always_comb
  begin
    rd_mux = 32'h0;
    case (paddr)
      dpbwm_pkg::CFG_OFF:
        rd_mux[2:0] = cfg_q;
      dpbwm_pkg::RSTAT_OFF:
      begin
        rd_mux[dpbwm_pkg::ADDR_W-1:0] = r_addr;
        rd_mux[dpbwm_pkg::STAT_LANE_POS +: 2] = r_lane;
      end
      dpbwm_pkg::LSTAT_OFF:
      begin
        rd_mux[dpbwm_pkg::ADDR_W-1:0] = l_addr;
        rd_mux[dpbwm_pkg::STAT_LANE_POS +: 2] = l_lane;
      end
      default:
        rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= apb_setup;
      pslverr <= apb_setup && !addr_ok;
      prdata <= (apb_setup && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // New configuration is used from the edge after the write completes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_q <= dpbwm_pkg::CFG_RESET;
    else if (apb_access && pwrite && (paddr == dpbwm_pkg::CFG_OFF))
      cfg_q <= pwdata[2:0];
  end

endmodule

// *** testbench/dpbwm_mem_model.sv ***
// Array behind one port: read at once, lane-masked write.
// Assumes the write pulse belongs to the address of the cycle before it.
module dpbwm_mem_model (
  input wire logic clk,
  input wire logic [dpbwm_pkg::ADDR_W-1:0] addr,
  input wire logic [dpbwm_pkg::DATA_W-1:0] wdata,
  input wire logic [dpbwm_pkg::LANES-1:0] lane_we,
  output logic [dpbwm_pkg::DATA_W-1:0] rdata
);
  logic [dpbwm_pkg::DATA_W-1:0] mem [2**dpbwm_pkg::ADDR_W];
  logic [dpbwm_pkg::ADDR_W-1:0] addr_q;

  assign rdata = mem[addr];

  // The counter may already have stepped when the pulse shows
  always @(posedge clk)
  begin
    addr_q <= addr;
    for (int k = 0; k < dpbwm_pkg::LANES; k++)
    begin
      if (lane_we[k])
      begin
        mem[addr_q][k*9 +: 9] <= wdata[k*9 +: 9];
      end
    end
  end
endmodule

// *** testbench/dpbwm_top_sva.sv ***
// Port assertions for the bus-width matcher top.
// Bound into dpbwm_top; reads its ports only.
module dpbwm_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic r_load_strobe_n,
  input wire logic r_advance_enable_n,
  input wire logic r_counter_clear_n,
  input wire logic r_write,
  input wire logic r_read,
  input wire logic [dpbwm_pkg::ADDR_W-1:0] r_ext_addr,
  input wire logic [dpbwm_pkg::DATA_W-1:0] r_dq_oe,
  input wire logic [dpbwm_pkg::ADDR_W-1:0] r_mem_addr,
  input wire logic [dpbwm_pkg::LANES-1:0] r_mem_lane_we
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Sequences
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_load;
    r_counter_clear_n && !r_load_strobe_n && !r_advance_enable_n;
  endsequence

  // ==========================================================
  // Properties
  a_apb_answer: assert property (s_setup |=> pready ##1 !pready)
    else $error("ready is not one access-cycle pulse");
  a_load_addr: assert property (s_load |=> r_mem_addr == $past(r_ext_addr))
    else $error("load missed the external address");
  a_clear_zero: assert property (!r_counter_clear_n |=> r_mem_addr == 15'h0)
    else $error("clear left the counter nonzero");
  a_hold_addr: assert property (
    r_counter_clear_n && r_advance_enable_n |=> $stable(r_mem_addr))
    else $error("counter moved without advance");
  a_we_cause: assert property (
    r_mem_lane_we != 4'h0 |-> $past(r_write)
      && r_mem_lane_we inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf})
    else $error("lane write without a legal beat");
  a_write_we: assert property (r_write |=> r_mem_lane_we != 4'h0)
    else $error("write beat lost");
  a_oe_cause: assert property (
    r_dq_oe != 36'h0 |-> $past(r_read) && !$past(r_write))
    else $error("pins driven without a read");
  a_write_noe: assert property (r_write |=> r_dq_oe == 36'h0)
    else $error("pins driven during a write");
endmodule

bind dpbwm_top dpbwm_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .r_load_strobe_n(r_load_strobe_n),
  .r_advance_enable_n(r_advance_enable_n), .r_counter_clear_n(r_counter_clear_n),
  .r_write(r_write), .r_read(r_read), .r_ext_addr(r_ext_addr), .r_dq_oe(r_dq_oe),
  .r_mem_addr(r_mem_addr), .r_mem_lane_we(r_mem_lane_we));

// *** testbench/tb_top.sv ***
// Self-checking bench for the bus-width matcher, one array model a port.
// Assumes the design package and the checker are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  `define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("unexpected at %0t: mismatch", $time); end end

  localparam logic [35:0] WORD = 36'h9abcdef12;
  localparam logic [2:0] CFGS [5] = '{3'h4, 3'h1, 3'h5, 3'h3, 3'h7};
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic pready, pslverr, er;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic l_load_strobe_n = 1'h1, l_advance_enable_n = 1'h1, l_counter_clear_n = 1'h1;
  logic l_write = 1'h0, l_read = 1'h0, l_lane0_mask_n = 1'h1, l_lane1_mask_n = 1'h1;
  logic l_lane2_mask_n = 1'h1, l_lane3_mask_n = 1'h1, r_write = 1'h0, r_read = 1'h0;
  logic r_load_strobe_n = 1'h1, r_advance_enable_n = 1'h1, r_counter_clear_n = 1'h1;
  logic [14:0] l_ext_addr = 15'h0, r_ext_addr = 15'h0, l_mem_addr, r_mem_addr;
  logic [35:0] l_dq_in = 36'h0, r_dq_in = 36'h0, l_dq_out, l_dq_oe, r_dq_out, r_dq_oe;
  logic [35:0] l_mem_wdata, l_mem_rdata, r_mem_wdata, r_mem_rdata;
  logic [3:0] l_mem_lane_we, r_mem_lane_we;
  int errors = 0;
  int checks = 0;

  dpbwm_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .l_load_strobe_n, .l_advance_enable_n, .l_counter_clear_n,
    .l_write, .l_read, .l_lane0_mask_n, .l_lane1_mask_n, .l_lane2_mask_n, .l_lane3_mask_n,
    .l_ext_addr, .l_dq_in, .l_dq_out, .l_dq_oe, .l_mem_addr, .l_mem_wdata, .l_mem_lane_we,
    .l_mem_rdata, .r_load_strobe_n, .r_advance_enable_n, .r_counter_clear_n, .r_write,
    .r_read, .r_ext_addr, .r_dq_in, .r_dq_out, .r_dq_oe, .r_mem_addr, .r_mem_wdata,
    .r_mem_lane_we, .r_mem_rdata);
  dpbwm_mem_model u_lmem (.clk(pclk), .addr(l_mem_addr), .wdata(l_mem_wdata),
    .lane_we(l_mem_lane_we), .rdata(l_mem_rdata));
  dpbwm_mem_model u_rmem (.clk(pclk), .addr(r_mem_addr), .wdata(r_mem_wdata),
    .lane_we(r_mem_lane_we), .rdata(r_mem_rdata));

  always #50 pclk = ~pclk;

  // ==========================================================
  // Bus and port tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 16)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'h1)
    begin
      errors++;
      $display("unexpected at %0t: no ready", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Outputs seen after a call belong to the request of the call before
  task automatic cyc(input logic clr_n, input logic ld_n, input logic adv_n, input logic wr,
      input logic rdn, input logic [14:0] a, input logic [35:0] d);
    @(posedge pclk);
    r_counter_clear_n <= clr_n;
    r_load_strobe_n <= ld_n;
    r_advance_enable_n <= adv_n;
    r_write <= wr;
    r_read <= rdn;
    r_ext_addr <= a;
    r_dq_in <= d;
    #1;
  endtask

  task automatic burst(input logic wr, input logic [2:0] c, input logic [14:0] a);
    int n;
    int kd;
    int kp;
    logic [35:0] m;
    n = c[0] ? (c[1] ? 4 : 2) : 1;
    m = (36'h1 << (36 / n)) - 36'h1;
    cyc(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, a, 36'h0);
    for (int i = 0; i <= n; i++)
    begin
      kd = (c[2] && n > 1) ? n - 1 - i : i;
      kp = kd + ((c[2] && n > 1) ? 1 : -1);
      if (i < n)
        cyc(1'h1, 1'h1, 1'h0, wr, !wr, a, (WORD >> (kd * 36 / n)) & m);
      else
        cyc(1'h1, 1'h1, 1'h1, 1'h0, 1'h0, a, 36'h0);
      if (i > 0 && wr)
        `CHK(r_mem_lane_we, n == 1 ? 4'hf : n == 2 ? 4'h3 << (2 * kp) : 4'h1 << kp)
      if (i > 0 && !wr)
        `CHK(r_dq_out & m, (WORD >> (kp * 36 / n)) & m)
      if (i > 0 && !wr)
        `CHK(r_dq_oe, m)
      if (i > 0)
        `CHK(r_mem_addr, i == n ? a + 15'h1 : a)
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, dpbwm_pkg::CFG_OFF, 32'h0);
    `CHK(rd, {29'h0, dpbwm_pkg::CFG_RESET})
    apb(1'h0, 8'h0c, 32'h0);
    `CHK(er, 1'h1)
    // x36 with order high first: order must not matter there
    for (int j = 0; j < 5; j++)
    begin
      apb(1'h1, dpbwm_pkg::CFG_OFF, {29'h0, CFGS[j]});
      burst(1'h1, CFGS[j], 15'h7fff - 15'(j));
      burst(1'h0, CFGS[j], 15'h7fff - 15'(j));
    end
    apb(1'h1, dpbwm_pkg::CFG_OFF, 32'h0);
    cyc(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 15'h1234, 36'h0);
    cyc(1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 15'h0777, 36'h0);
    cyc(1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 15'h0, 36'h0);
    `CHK(r_dq_out[17:3], 15'h1234)
    apb(1'h0, dpbwm_pkg::RSTAT_OFF, 32'h0);
    `CHK(rd[14:0], 15'h1234)
    cyc(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 15'h0055, 36'h0);
    cyc(1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 15'h0, 36'h0);
    `CHK(r_mem_addr, 15'h0)
    @(posedge pclk);
    l_load_strobe_n <= 1'h0;
    l_advance_enable_n <= 1'h0;
    l_ext_addr <= 15'h0100;
    @(posedge pclk);
    l_load_strobe_n <= 1'h1;
    l_write <= 1'h1;
    l_dq_in <= WORD;
    l_lane0_mask_n <= 1'h0;
    l_lane2_mask_n <= 1'h0;
    @(posedge pclk);
    l_write <= 1'h0;
    l_advance_enable_n <= 1'h1;
    #1;
    `CHK(l_mem_lane_we, 4'h5)
    `CHK(l_mem_wdata, WORD)
    `CHK(l_mem_addr, 15'h0101)
    // Read back the masked word, then the held counter
    @(posedge pclk);
    l_load_strobe_n <= 1'h0;
    l_advance_enable_n <= 1'h0;
    @(posedge pclk);
    l_load_strobe_n <= 1'h1;
    l_advance_enable_n <= 1'h1;
    l_read <= 1'h1;
    @(posedge pclk);
    l_load_strobe_n <= 1'h0;
    #1;
    `CHK(l_dq_out, 36'h003cc0112)
    `CHK(l_dq_oe, 36'h007fc01ff)
    @(posedge pclk);
    l_load_strobe_n <= 1'h1;
    l_read <= 1'h0;
    #1;
    `CHK(l_dq_out[17:3], 15'h0100)
    `CHK(l_dq_oe, 36'hfffffffff)
    // Narrow counter readback, x18 swapped then x9 swapped
    apb(1'h1, dpbwm_pkg::CFG_OFF, 32'h5);
    cyc(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 15'h1234, 36'h0);
    cyc(1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 15'h0, 36'h0);
    cyc(1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 15'h0, 36'h0);
    `CHK(r_dq_out[17:2], {15'h1234, 1'h1})
    `CHK(r_dq_oe, 36'h00003ffff)
    apb(1'h0, dpbwm_pkg::RSTAT_OFF, 32'h0);
    `CHK(rd[17:0], {2'h2, 1'h0, 15'h1234})
    apb(1'h1, dpbwm_pkg::CFG_OFF, 32'h7);
    cyc(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 15'h1234, 36'h0);
    cyc(1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 15'h0, 36'h0);
    cyc(1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 15'h0, 36'h0);
    `CHK(r_dq_out[8:0], 9'h048)
    cyc(1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 15'h0, 36'h0);
    `CHK(r_dq_out[8:1], {6'h34, 2'h3})
    `CHK(r_dq_oe, 36'h0000001ff)
    finish_test();
  end

  initial
  begin
    #1000000;
    errors++;
    finish_test();
  end
endmodule
